// *** hdl/csw_mem_map.sv ***
// status word, internal/external data memory and address decode
// assumes the execution core issues at most one request per cycle
// Overview of operation
// - carry bit 7 set on add carry or subtract borrow, else cleared
// - half carry bit 6 set on nibble carry or borrow, else cleared
// - bits 5 and 1 are software flags, byte and bit writable
// - bank select bits 4:3 place R0-R7 at bank times eight
// - overflow bit 2 on signed overflow, product above 255, divide by zero
// - bit 0 is read-only odd parity of the accumulator
// - code space 0x0000-0x1fff, top 0x1e00-0x1fff reserved
// - program memory has no write path, read only by code read
// - lower 128 bytes direct or indirect, upper 128 indirect only
// - above 0x7f direct selects special registers, indirect upper ram
// - bit addresses 0x00-0x7f map to bytes 0x20-0x2f
// - indirect pointer comes from R0 or R1 of current bank
// - push stores at pointer plus one then increments pointer
// - reset loads stack pointer with 0x07
// - 512 bytes external ram via data pointer or 8-bit pointer
// - 8-bit external moves take address bit 8 from page register
// - 16-bit external moves ignore top seven address bits
// - page register holds only bit 0, others read zero
`timescale 1ns/1ps
`default_nettype none
module csw_mem_map
    import csw_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire csw_req_t    req,
    input  wire logic [7:0]  acc,
    output var  csw_rsp_t    rsp_q,
    output var  logic [7:0]  status_word_q,
    output var  logic        code_req_q,
    output var  logic [15:0] code_addr_q,
    output var  logic        code_fault_q
);
    // ****************************************
    // storage
    // ****************************************
    logic [7:0]  iram [IRAM_WORDS];
    logic [7:0]  onchip_ext_ram [ONCHIP_EXT_RAM_WORDS];
    logic [7:0]  stack_ptr_q;
    logic [15:0] data_pointer_q;
    logic        page_bit_q;

    logic [1:0]  bank_select;
    logic [7:0]  ptr;
    logic [7:0]  ea;
    logic        is_sfr;
    logic [7:0]  sfr_rd;
    logic [7:0]  cur;
    logic [7:0]  wbyte;
    logic [8:0]  xa;
    logic [15:0] code_a;

    // bit address to the byte that holds it
    function automatic logic [7:0] bit_byte(input logic [7:0] a);
        if (a[7]) begin
            return {a[7:3], 3'b000};
        end
        return BIT_BASE + {4'h0, a[6:3]};
    endfunction

    assign bank_select = status_word_q[BANK_HI:BANK_LO];
    assign ptr = iram[{3'b000, bank_select, 2'b00, req.addr[0]}];

    // ****************************************
    // address decode
    // ****************************************
    always_comb begin
        ea     = req.addr;
        is_sfr = 1'b0;
        case (req.mode)
            MODE_DIRECT: begin
                ea     = req.addr;
                is_sfr = req.addr[7];
            end
            MODE_INDIRECT: begin
                ea     = ptr;
                is_sfr = 1'b0;
            end
            MODE_BIT: begin
                ea     = bit_byte(req.addr);
                is_sfr = req.addr[7];
            end
            default: begin
                ea     = {3'b000, bank_select, req.addr[2:0]};
                is_sfr = 1'b0;
            end
        endcase
    end

    // unmapped special registers read as zero
    always_comb begin
        if (ea == SFR_SP) begin
            sfr_rd = stack_ptr_q;
        end else if (ea == SFR_DPL) begin
            sfr_rd = data_pointer_q[7:0];
        end else if (ea == SFR_DPH) begin
            sfr_rd = data_pointer_q[15:8];
        end else if (ea == SFR_PAGE) begin
            sfr_rd = {7'h00, page_bit_q};
        end else if (ea == SFR_STATUS) begin
            sfr_rd = status_word_q;
        end else begin
            sfr_rd = 8'h00;
        end
    end

    assign cur = is_sfr ? sfr_rd : iram[ea];

    // bit writes are read-modify-write of the holding byte
    always_comb begin
        wbyte = req.wdata;
        if (req.mode == MODE_BIT) begin
            wbyte = cur;
            wbyte[req.addr[2:0]] = req.wdata[0];
        end
    end

    assign xa = req.x16 ? data_pointer_q[8:0]
                        : {page_bit_q, ptr};
    assign code_a = data_pointer_q + {8'h00, acc};

    // ****************************************
    // flag arithmetic
    // ****************************************
    logic       cin;
    logic [8:0] add9;
    logic [4:0] addn;
    logic [8:0] sub9;
    logic [4:0] subn;
    logic [15:0] prod;

    assign cin  = (req.alu == ALU_ADD) ? 1'b0 : status_word_q[CY_POS];
    assign add9 = {1'b0, acc} + {1'b0, req.wdata} + {8'h00, cin};
    assign addn = {1'b0, acc[3:0]} + {1'b0, req.wdata[3:0]} + {4'h0, cin};
    assign sub9 = {1'b0, acc} - {1'b0, req.wdata} - {8'h00, cin};
    assign subn = {1'b0, acc[3:0]} - {1'b0, req.wdata[3:0]} - {4'h0, cin};
    assign prod = acc * req.wdata;

    // ****************************************
    // status word
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_word_q <= STATUS_RST;
        end else begin
            // one cycle of latency keeps the acc path out of the bus read
            status_word_q[PAR_POS] <= ^acc;
            if (req.op == OP_ALU) begin
                case (req.alu)
                    ALU_ADD, ALU_ADD_WITH_CARRY_OP: begin
                        status_word_q[CY_POS] <= add9[8];
                        status_word_q[AC_POS] <= addn[4];
                        status_word_q[OV_POS] <= (acc[7] == req.wdata[7])
                            && (add9[7] != acc[7]);
                    end
                    ALU_SUB_WITH_BORROW_OP: begin
                        status_word_q[CY_POS] <= sub9[8];
                        status_word_q[AC_POS] <= subn[4];
                        status_word_q[OV_POS] <= (acc[7] != req.wdata[7])
                            && (sub9[7] != acc[7]);
                    end
                    ALU_MUL: begin
                        status_word_q[CY_POS] <= 1'b0;
                        status_word_q[AC_POS] <= 1'b0;
                        status_word_q[OV_POS] <= prod[15:8] != 8'h00;
                    end
                    ALU_DIV: begin
                        status_word_q[CY_POS] <= 1'b0;
                        status_word_q[AC_POS] <= 1'b0;
                        status_word_q[OV_POS] <= req.wdata == 8'h00;
                    end
                    default: begin
                        status_word_q[CY_POS] <= 1'b0;
                        status_word_q[AC_POS] <= 1'b0;
                    end
                endcase
            end else if (req.op == OP_WRITE && is_sfr && ea == SFR_STATUS) begin
                // parity bit is never written
                status_word_q[7:1] <= wbyte[7:1];
            end
        end
    end

    // ****************************************
    // stack pointer, data pointer, page
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_ptr_q <= SP_RST;
        end else if (req.op == OP_PUSH) begin
            stack_ptr_q <= stack_ptr_q + 8'h01;
        end else if (req.op == OP_POP) begin
            stack_ptr_q <= stack_ptr_q - 8'h01;
        end else if (req.op == OP_WRITE && is_sfr && ea == SFR_SP) begin
            stack_ptr_q <= wbyte;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_pointer_q <= DATA_POINTER_RST;
        end else if (req.op == OP_WRITE && is_sfr && ea == SFR_DPL) begin
            data_pointer_q[7:0] <= wbyte;
        end else if (req.op == OP_WRITE && is_sfr && ea == SFR_DPH) begin
            data_pointer_q[15:8] <= wbyte;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_bit_q <= PAGE_RST;
        end else if (req.op == OP_WRITE && is_sfr && ea == SFR_PAGE) begin
            page_bit_q <= wbyte[0];
        end
    end

    // ****************************************
    // memories
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (req.op == OP_PUSH) begin
            iram[stack_ptr_q + 8'h01] <= req.wdata;
        end else if (req.op == OP_WRITE && !is_sfr) begin
            iram[ea] <= wbyte;
        end
    end

    always_ff @(posedge core_clk) begin
        if (req.op == OP_XWR) begin
            onchip_ext_ram[xa] <= req.wdata;
        end
    end

    // ****************************************
    // read answers and code port
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid <= 1'b0;
            if (req.op == OP_READ) begin
                rsp_q.valid <= 1'b1;
                rsp_q.data  <= (req.mode == MODE_BIT)
                    ? {7'h00, cur[req.addr[2:0]]} : cur;
            end else if (req.op == OP_POP) begin
                rsp_q.valid <= 1'b1;
                rsp_q.data  <= iram[stack_ptr_q];
            end else if (req.op == OP_XRD) begin
                rsp_q.valid <= 1'b1;
                rsp_q.data  <= onchip_ext_ram[xa];
            end
        end
    end

    // no write path reaches program memory at all
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            code_req_q   <= 1'b0;
            code_addr_q  <= 16'h0000;
            code_fault_q <= 1'b0;
        end else begin
            code_req_q   <= (req.op == OP_CODE) && (code_a < CODE_RSV);
            code_fault_q <= (req.op == OP_CODE) && (code_a >= CODE_RSV);
            if (req.op == OP_CODE) begin
                code_addr_q <= code_a;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_push_sp_inc: assert property (
        req.op == OP_PUSH |=> stack_ptr_q == $past(stack_ptr_q) + 8'h01)
        else $error("push did not advance stack pointer");
    a_push_slot: assert property (
        req.op == OP_PUSH |=> iram[stack_ptr_q] == $past(req.wdata))
        else $error("pushed byte not at new top");
    a_parity_follow: assert property (
        ##1 status_word_q[PAR_POS] == ^$past(acc))
        else $error("parity does not track accumulator");
    a_carry_add: assert property (
        req.op == OP_ALU && req.alu == ALU_ADD
        |=> status_word_q[CY_POS]
            == (({1'b0, $past(acc)} + {1'b0, $past(req.wdata)}) > 9'h0ff))
        else $error("add carry wrong");
    a_div_zero_ov: assert property (
        req.op == OP_ALU && req.alu == ALU_DIV && req.wdata == 8'h00
        |=> status_word_q[OV_POS] && !status_word_q[CY_POS])
        else $error("divide by zero not flagged");
    a_page_high_zero: assert property (
        req.op == OP_READ && req.mode == MODE_DIRECT && req.addr == SFR_PAGE
        |=> rsp_q.valid && rsp_q.data[7:1] == 7'h00)
        else $error("page register high bits not zero");
    a_direct_sfr_sp: assert property (
        req.op == OP_READ && req.mode == MODE_DIRECT && req.addr == SFR_SP
        |=> rsp_q.data == $past(stack_ptr_q))
        else $error("direct read missed special register");
    a_code_reserved: assert property (
        req.op == OP_CODE && code_a >= CODE_RSV
        |=> code_fault_q && !code_req_q)
        else $error("reserved code read not refused");
    a_half_carry: assert property (
        req.op == OP_ALU && req.alu == ALU_SUB_WITH_BORROW_OP
        |=> status_word_q[AC_POS] == ({1'b0, $past(acc[3:0])}
            < ({1'b0, $past(req.wdata[3:0])} + {4'h0, $past(status_word_q[CY_POS])})))
        else $error("half borrow wrong");

    c_push: cover property (req.op == OP_PUSH ##1 req.op == OP_POP);
    c_bank3: cover property (bank_select == 2'b11 && req.mode == MODE_INDIRECT);
    c_xpage: cover property (req.op == OP_XRD && !req.x16 && page_bit_q);
endmodule // csw_mem_map
`default_nettype wire

// *** hdl/csw_pkg.sv ***
// constants and carrier types for the status word and data memory map
// assumes one clock domain shared with the execution core
package csw_pkg;
    // ****************************************
    // special register offsets
    // ****************************************
    localparam logic [7:0]  SFR_SP       = 8'h81;
    localparam logic [7:0]  SFR_DPL      = 8'h82;
    localparam logic [7:0]  SFR_DPH      = 8'h83;
    localparam logic [7:0]  SFR_PAGE     = 8'haa;
    localparam logic [7:0]  SFR_STATUS   = 8'hd0;
    // ****************************************
    // reset values and field positions
    // ****************************************
    localparam logic [7:0]  SP_RST       = 8'h07;
    localparam logic [7:0]  STATUS_RST   = 8'h00;
    localparam logic [15:0] DATA_POINTER_RST     = 16'h0000;
    localparam logic        PAGE_RST     = 1'b0;
    localparam int          CY_POS       = 7;
    localparam int          AC_POS       = 6;
    localparam int          UA_POS       = 5;
    localparam int          BANK_HI      = 4;
    localparam int          BANK_LO      = 3;
    localparam int          OV_POS       = 2;
    localparam int          UB_POS       = 1;
    localparam int          PAR_POS      = 0;
    // ****************************************
    // memory map
    // ****************************************
    localparam logic [7:0]  BIT_BASE     = 8'h20;
    localparam logic [15:0] CODE_RSV     = 16'h1e00;
    localparam int          IRAM_WORDS   = 256;
    localparam int          ONCHIP_EXT_RAM_WORDS   = 512;

    typedef enum logic [3:0] {
        OP_NONE  = 4'h0,
        OP_READ  = 4'h1,
        OP_WRITE = 4'h2,
        OP_PUSH  = 4'h3,
        OP_POP   = 4'h4,
        OP_XRD   = 4'h5,
        OP_XWR   = 4'h6,
        OP_CODE  = 4'h7,
        OP_ALU   = 4'h8
    } csw_op_t;

    typedef enum logic [1:0] {
        MODE_DIRECT   = 2'b00,
        MODE_INDIRECT = 2'b01,
        MODE_BIT      = 2'b10,
        MODE_REG      = 2'b11
    } csw_mode_t;

    typedef enum logic [2:0] {
        ALU_ADD   = 3'b000,
        ALU_ADD_WITH_CARRY_OP  = 3'b001,
        ALU_SUB_WITH_BORROW_OP  = 3'b010,
        ALU_MUL   = 3'b011,
        ALU_DIV   = 3'b100,
        ALU_OTHER = 3'b101
    } csw_alu_t;

    typedef struct packed {
        csw_op_t   op;
        csw_mode_t mode;
        csw_alu_t  alu;
        logic      x16;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csw_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } csw_rsp_t;
endpackage

// *** verification/csw_core_model.sv ***
// execution core model: issues one memory request at a time
// assumes the design takes a request at the edge after it is driven
`timescale 1ns/1ps
`default_nettype none
module csw_core_model
    import csw_pkg::*;
(
    input  wire logic       core_clk,
    output var  csw_req_t   req,
    output var  logic [7:0] acc
);
    initial begin
        req = '0;
        acc = 8'h00;
    end
    // idle wdata is inverted so a stale operand is never mistaken for a live one
    task automatic issue(input csw_op_t op, input csw_mode_t md, input csw_alu_t alu,
                         input logic x, input logic [7:0] ad, input logic [7:0] wd,
                         input logic [7:0] a);
        @(posedge core_clk);
        req <= '{op, md, alu, x, ad, wd};
        acc <= a;
        @(posedge core_clk);
        req.op    <= OP_NONE;
        req.wdata <= ~wd;
        #1;
    endtask
endmodule // csw_core_model
`default_nettype wire

// *** verification/test_cpu_status_word_and_data_memory_map.sv ***
// self-checking bench for the status word and data memory map
// assumes csw_core_model drives every request and the accumulator
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module test_cpu_status_word_and_data_memory_map
    import csw_pkg::*;
;
    logic        core_clk;
    logic        rst_n;
    csw_req_t    req;
    logic [7:0]  acc;
    csw_rsp_t    rsp_q;
    logic [7:0]  status_word_q;
    logic        code_req_q;
    logic [15:0] code_addr_q;
    logic        code_fault_q;
    int          err_total;
    int          checked;
    int          seed;
    int          a;
    int          b;
    logic [7:0]  psw_m;
    logic [7:0]  acc_m;
    logic [7:0]  stk_m[$];

    csw_mem_map dut (.core_clk(core_clk), .rst_n(rst_n), .req(req), .acc(acc),
        .rsp_q(rsp_q), .status_word_q(status_word_q), .code_req_q(code_req_q),
        .code_addr_q(code_addr_q), .code_fault_q(code_fault_q));
    csw_core_model core (.core_clk(core_clk), .req(req), .acc(acc));

    // ****************************************
    // reference model and access tasks
    // ****************************************
    function automatic logic [7:0] flags(int k, int a, int b, logic [7:0] p);
        int ci, sa, sb, r;
        ci = (k == 1 || k == 2) ? int'(p[7]) : 0;
        sa = (a > 127) ? a - 256 : a;
        sb = (b > 127) ? b - 256 : b;
        p[7:6] = 2'b00;
        case (k)
            0, 1: begin
                p[7] = (a + b + ci) > 255;
                p[6] = (a % 16 + b % 16 + ci) > 15;
                r = sa + sb + ci;
                p[2] = r > 127 || r < -128;
            end
            2: begin
                p[7] = a < b + ci;
                p[6] = a % 16 < b % 16 + ci;
                r = sa - sb - ci;
                p[2] = r > 127 || r < -128;
            end
            3: p[2] = a * b > 255;
            4: p[2] = b == 0;
            default: ;
        endcase
        p[0] = ^(8'(a));
        return p;
    endfunction

    task automatic wr(csw_mode_t md, logic [7:0] ad, logic [7:0] d);
        core.issue(OP_WRITE, md, ALU_OTHER, 1'b0, ad, d, acc_m);
    endtask

    task automatic rd(csw_op_t op, csw_mode_t md, logic x, logic [7:0] ad, logic [7:0] ex);
        core.issue(op, md, ALU_OTHER, x, ad, 8'h00, acc_m);
        `CHK(rsp_q.valid, 1'b1)
        `CHK(rsp_q.data, ex)
    endtask

    task automatic code_rd(logic [7:0] av, logic [15:0] ad, logic flt);
        core.issue(OP_CODE, MODE_DIRECT, ALU_OTHER, 1'b0, 8'h00, 8'h00, av);
        `CHK(code_addr_q, ad)
        `CHK(code_fault_q, flt)
        `CHK(code_req_q, !flt)
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // clock, reset, watchdog
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        print_verdict();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        rst_n = 1'b0;
        err_total = 0;
        checked = 0;
        seed = 32'h2ced1952;
        acc_m = 8'h00;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(OP_READ, MODE_DIRECT, 1'b0, SFR_SP, SP_RST);
        rd(OP_READ, MODE_DIRECT, 1'b0, SFR_STATUS, STATUS_RST);
        stk_m.push_back(8'h5a);
        core.issue(OP_PUSH, MODE_DIRECT, ALU_OTHER, 1'b0, 8'h00, 8'h5a, acc_m);
        stk_m.push_back(8'ha5);
        core.issue(OP_PUSH, MODE_DIRECT, ALU_OTHER, 1'b0, 8'h00, 8'ha5, acc_m);
        rd(OP_READ, MODE_DIRECT, 1'b0, 8'h08, stk_m[0]);
        rd(OP_READ, MODE_DIRECT, 1'b0, SFR_SP, 8'h09);
        rd(OP_POP, MODE_DIRECT, 1'b0, 8'h00, stk_m.pop_back());
        rd(OP_READ, MODE_DIRECT, 1'b0, SFR_SP, 8'h08);
        for (int k = 0; k < 4; k++) begin
            wr(MODE_DIRECT, SFR_STATUS, 8'(k << 3));
            `CHK(status_word_q, 8'(k << 3))
            wr(MODE_REG, 8'h07, 8'(8'h40 + k));
            rd(OP_READ, MODE_DIRECT, 1'b0, 8'(k * 8 + 7), 8'(8'h40 + k));
        end
        wr(MODE_REG, 8'h01, 8'h90);
        wr(MODE_REG, 8'h00, 8'h30);
        wr(MODE_INDIRECT, 8'h01, 8'h3c);
        wr(MODE_INDIRECT, 8'h00, 8'h77);
        rd(OP_READ, MODE_INDIRECT, 1'b0, 8'h01, 8'h3c);
        rd(OP_READ, MODE_DIRECT, 1'b0, 8'h90, 8'h00);
        rd(OP_READ, MODE_DIRECT, 1'b0, 8'h30, 8'h77);
        wr(MODE_DIRECT, 8'h22, 8'h00);
        wr(MODE_DIRECT, 8'h2f, 8'h00);
        wr(MODE_BIT, 8'h13, 8'h01);
        wr(MODE_BIT, 8'h7f, 8'h01);
        rd(OP_READ, MODE_DIRECT, 1'b0, 8'h22, 8'h08);
        rd(OP_READ, MODE_DIRECT, 1'b0, 8'h2f, 8'h80);
        wr(MODE_DIRECT, SFR_STATUS, 8'h23);
        rd(OP_READ, MODE_DIRECT, 1'b0, SFR_STATUS, 8'h22);
        wr(MODE_BIT, 8'hd5, 8'h00);
        `CHK(status_word_q, 8'h02)
        wr(MODE_DIRECT, SFR_STATUS, 8'h00);
        psw_m = 8'h00;
        // last six passes force a zero operand so divide by zero is hit
        for (int i = 0; i < 66; i++) begin
            a = $random(seed) & 255;
            b = (i >= 60) ? 0 : $random(seed) & 255;
            psw_m = flags(i % 6, a, b, psw_m);
            acc_m = 8'(a);
            core.issue(OP_ALU, MODE_DIRECT, csw_alu_t'(i % 6), 1'b0, 8'h00, 8'(b), acc_m);
            `CHK(status_word_q, psw_m)
        end
        acc_m = ~acc_m;
        acc_m[0] = ~acc_m[0];
        core.issue(OP_NONE, MODE_DIRECT, ALU_OTHER, 1'b0, 8'h00, 8'h00, acc_m);
        `CHK(status_word_q[0], ^acc_m)
        wr(MODE_DIRECT, SFR_STATUS, 8'h00);
        wr(MODE_DIRECT, SFR_PAGE, 8'hff);
        rd(OP_READ, MODE_DIRECT, 1'b0, SFR_PAGE, 8'h01);
        wr(MODE_REG, 8'h00, 8'h34);
        core.issue(OP_XWR, MODE_INDIRECT, ALU_OTHER, 1'b0, 8'h00, 8'hc3, acc_m);
        wr(MODE_DIRECT, SFR_DPH, 8'hfd);
        wr(MODE_DIRECT, SFR_DPL, 8'h34);
        rd(OP_XRD, MODE_INDIRECT, 1'b1, 8'h00, 8'hc3);
        wr(MODE_DIRECT, SFR_DPH, 8'h02);
        wr(MODE_DIRECT, SFR_DPL, 8'h00);
        core.issue(OP_XWR, MODE_INDIRECT, ALU_OTHER, 1'b1, 8'h00, 8'h99, acc_m);
        wr(MODE_DIRECT, SFR_PAGE, 8'h00);
        wr(MODE_REG, 8'h00, 8'h00);
        rd(OP_XRD, MODE_INDIRECT, 1'b0, 8'h00, 8'h99);
        wr(MODE_DIRECT, SFR_DPH, 8'h1d);
        wr(MODE_DIRECT, SFR_DPL, 8'hf0);
        code_rd(8'h0f, 16'h1dff, 1'b0);
        code_rd(8'h10, 16'h1e00, 1'b1);
        print_verdict();
    end
endmodule // test_cpu_status_word_and_data_memory_map
`default_nettype wire
